// ### rtl/fault_pkg.sv
package fault_pkg;
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_DTO    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam logic [7:0] OP_BULK      = 8'h01;
  localparam logic [7:0] OP_DTO_QUERY = 8'h02;
  localparam logic [7:0] OP_DTO_SET   = 8'h03;
  localparam int         CMD_VAL_LSB  = 8;

  localparam int ST_BUSY   = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_BADVAL = 2;

  localparam logic [3:0] DTO_FOUR  = 4'h4;
  localparam logic [3:0] DTO_SEVEN = 4'h7;
  localparam logic [3:0] DTO_RESET = 4'h4;

  localparam logic [7:0] CH_CR         = 8'h0D;
  localparam logic [7:0] CH_LF         = 8'h0A;
  localparam logic [7:0] CH_DIGIT_BASE = 8'h30;
  localparam logic [1:0] CH_PRINT_TOP  = 2'h1;

  // Echo text, first byte in entry 0
  localparam logic [4:0][7:0] BULK_ECHO = {8'h5F, 8'h46, 8'h53, 8'h43, 8'h42};
  localparam logic [3:0][7:0] DTO_ECHO  = {8'h5F, 8'h4F, 8'h54, 8'h44};
  localparam logic [4:0] BULK_ECHO_LAST = 5'h04;
  localparam logic [4:0] DTO_ECHO_LAST  = 5'h03;
  localparam logic [4:0] BULK_BODY_LAST = 5'h1E;
  localparam int         BULK_CHARS     = 31;
  localparam int         NUM_TEN        = 11;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ECHO = 5'h02,
    S_BODY = 5'h04,
    S_CR   = 5'h08,
    S_LF   = 5'h10
  } tx_state_t;
endpackage

// ### rtl/pack_if.sv
`timescale 1ns/1ns
interface pack_if;
  logic [10:0][9:0] ten;
  logic [7:0]       mop;
  logic [7:0]       dop;
  logic [6:0]       dl;
  logic [6:0]       com;
  logic [7:0]       nodl;
  logic             cap;
  logic [4:0]       idx;
  logic [7:0]       chr;
  modport src (output ten, mop, dop, dl, com, nodl, cap, idx, input chr);
  modport pk  (input ten, mop, dop, dl, com, nodl, cap, idx, output chr);
endinterface

// ### rtl/status_char_packer.sv
`timescale 1ns/1ns
module status_char_packer (
  input  wire logic clk_in,
  input  wire logic rst_n,
  pack_if.pk        p
);
  logic [10:0][9:0] s_ten;
  logic [7:0]       s_mop;
  logic [7:0]       s_dop;
  logic [6:0]       s_dl;
  logic [6:0]       s_com;
  logic [7:0]       s_nodl;
  logic [7:0]       chars [0:30];
  localparam int TEN_POS [0:10] = '{0, 2, 9, 11, 13, 15, 19, 21, 23, 25, 29};

  function automatic logic [7:0] mk(input logic [5:0] b);
    mk = {fault_pkg::CH_PRINT_TOP, b};
  endfunction

  // Snapshot keeps one reply consistent while faults move underneath it
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_ten  <= '0;
      s_mop  <= 8'h00;
      s_dop  <= 8'h00;
      s_dl   <= 7'h00;
      s_com  <= 7'h00;
      s_nodl <= 8'h00;
    end else if (p.cap) begin
      s_ten  <= p.ten;
      s_mop  <= p.mop;
      s_dop  <= p.dop;
      s_dl   <= p.dl;
      s_com  <= p.com;
      s_nodl <= p.nodl;
    end
  end

  genvar g;
  generate
    for (g = 0; g < fault_pkg::NUM_TEN; g++) begin : g_ten
      assign chars[TEN_POS[g]] = mk({s_ten[g][0], s_ten[g][1], s_ten[g][2],
                                     s_ten[g][3], s_ten[g][4], s_ten[g][5]});
      assign chars[TEN_POS[g]+1] = mk({s_ten[g][6], s_ten[g][7], s_ten[g][8],
                                       s_ten[g][9], 2'b00});
    end
  endgenerate

  assign chars[4]  = mk({s_mop[0], s_mop[1], s_mop[2], s_mop[3], s_mop[4], s_mop[5]});
  assign chars[5]  = mk({s_mop[6], s_mop[7], 4'h0});
  assign chars[6]  = mk({s_dop[0], s_dop[1], s_dop[2], s_dop[3], s_dop[4], s_dop[5]});
  assign chars[7]  = mk({s_dop[6], s_dop[7], s_dl[0], s_dl[1], s_dl[2], s_dl[3]});
  assign chars[8]  = mk({s_dl[4], s_dl[5], s_dl[6], 3'h0});
  assign chars[17] = mk({s_com[0], s_com[1], s_com[2], s_com[3], s_com[4], s_com[5]});
  assign chars[18] = mk({s_com[6], 5'h00});
  assign chars[27] = mk({s_nodl[0], s_nodl[1], s_nodl[2], s_nodl[3], s_nodl[4], s_nodl[5]});
  assign chars[28] = mk({s_nodl[6], s_nodl[7], 4'h0});

  assign p.chr = (p.idx < 5'(fault_pkg::BULK_CHARS)) ? chars[p.idx] : 8'h00;

  a_common_order: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(p.cap) |-> chars[17][5:0] ==
      {$past(p.com[0]), $past(p.com[1]), $past(p.com[2]),
       $past(p.com[3]), $past(p.com[4]), $past(p.com[5])})
    else $error("common equipment character misordered");
  a_addr_batt_bit: assert property (@(posedge clk_in) disable iff (!rst_n)
    p.idx == 5'h12 |-> p.chr == {fault_pkg::CH_PRINT_TOP, s_com[6], 5'h00})
    else $error("second common character wrong");
  a_mod_cfg_two: assert property (@(posedge clk_in) disable iff (!rst_n)
    $past(p.cap) |-> chars[10][5:0] ==
      {$past(p.ten[2][6]), $past(p.ten[2][7]), $past(p.ten[2][8]),
       $past(p.ten[2][9]), 2'b00})
    else $error("second modulator verify character wrong");
  a_nodl_reserved: assert property (@(posedge clk_in) disable iff (!rst_n)
    p.idx == 5'h1C |-> p.chr[3:0] == 4'h0 && p.chr[6])
    else $error("no-downlink character reserved bits set");
endmodule

// ### rtl/bulk_fault_status_packer.sv
`timescale 1ns/1ns
// How it works
// - bit 6 of every status character is 1
// - mod verify char 2: primes 7-8, backups
// - demod verify char 1: primes 1-6
// - demod verify char 2: primes 7-8, backups
// - mod compatibility char 1: primes 1-6
// - mod compatibility char 2: primes 7-8, backups
// - demod compatibility char 1: primes 1-6
// - demod compatibility char 2: primes 7-8, backups
// - common char 1: supplies and control battery
// - common char 2: decoder battery, rest zero
// - missing mod configuration, characters one, two
// - missing demod configuration, characters three, four
// - modems without address, characters five, six
// - modems without interface, characters seven, eight
// - primes without downlink, characters nine, ten
// - final two characters: modem communication faults
// - four: two backups; seven: backup one
// - downlink count set or queried, value echoed
// - downlinks five to seven only when seven
// - fault bit is 1 while fault exists
// - bulk reply: echo, characters, CR, LF
module bulk_fault_status_packer (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [9:0]  mod_fault_in,
  input  wire logic [9:0]  dmd_fault_in,
  input  wire logic [7:0]  mod_op_fault_in,
  input  wire logic [7:0]  dmd_op_fault_in,
  input  wire logic [6:0]  downlink_fault_in,
  input  wire logic [9:0]  mod_cfg_fault_in,
  input  wire logic [9:0]  dmd_cfg_fault_in,
  input  wire logic [9:0]  mod_compat_fault_in,
  input  wire logic [9:0]  dmd_compat_fault_in,
  input  wire logic [6:0]  common_fault_in,
  input  wire logic [9:0]  no_mod_cfg_in,
  input  wire logic [9:0]  no_dmd_cfg_in,
  input  wire logic [9:0]  no_address_in,
  input  wire logic [9:0]  no_interface_in,
  input  wire logic [7:0]  no_downlink_in,
  input  wire logic [9:0]  comm_fault_in,
  output logic      [7:0]  tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic      [6:0]  downlink_enable_out,
  output logic             backup2_enable_out,
  output logic      [3:0]  downlink_count_option_out
);
  logic [1:0]            rst_sync;
  logic                  rst_n;
  fault_pkg::tx_state_t  st;
  logic [4:0]            cnt;
  logic                  is_bulk;
  logic [3:0]            downlink_count_option;
  logic                  rejected;
  logic                  bad_value;
  logic [7:0]            cur_byte;
  logic                  setup;
  logic                  wr;
  logic                  mapped;
  logic                  cmd_wr;
  logic [7:0]            op;
  logic [3:0]            val;
  logic                  op_known;
  logic                  accept;
  logic                  load;
  logic                  busy;
  logic                  val_ok;

  pack_if pk ();

  status_char_packer u_packer (
    .clk_in (clk_in),
    .rst_n  (rst_n),
    .p      (pk.pk)
  );

  // Reset takes hold asynchronously but is released in step with the clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign pk.ten[0]  = mod_fault_in;
  assign pk.ten[1]  = dmd_fault_in;
  assign pk.ten[2]  = mod_cfg_fault_in;
  assign pk.ten[3]  = dmd_cfg_fault_in;
  assign pk.ten[4]  = mod_compat_fault_in;
  assign pk.ten[5]  = dmd_compat_fault_in;
  assign pk.ten[6]  = no_mod_cfg_in;
  assign pk.ten[7]  = no_dmd_cfg_in;
  assign pk.ten[8]  = no_address_in;
  assign pk.ten[9]  = no_interface_in;
  assign pk.ten[10] = comm_fault_in;
  assign pk.mop     = mod_op_fault_in;
  assign pk.dop     = dmd_op_fault_in;
  assign pk.dl      = downlink_fault_in;
  assign pk.com     = common_fault_in;
  assign pk.nodl    = no_downlink_in;
  assign pk.idx     = cnt;
  assign pk.cap     = accept && op == fault_pkg::OP_BULK;

  // APB decode; the slave never waits
  assign pready_out = 1'b1;
  assign setup      = psel_in && !penable_in;
  assign wr         = psel_in && penable_in && pwrite_in;
  assign mapped     = paddr_in == fault_pkg::ADDR_CMD || paddr_in == fault_pkg::ADDR_DTO ||
                      paddr_in == fault_pkg::ADDR_STATUS;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign cmd_wr     = wr && paddr_in == fault_pkg::ADDR_CMD;
  assign op         = pwdata_in[7:0];
  assign val        = pwdata_in[fault_pkg::CMD_VAL_LSB +: 4];
  assign op_known   = op == fault_pkg::OP_BULK || op == fault_pkg::OP_DTO_QUERY ||
                      op == fault_pkg::OP_DTO_SET;
  assign busy       = st != fault_pkg::S_IDLE || tx_valid_out;
  // A command that arrives before the sequencer is back in idle is dropped rather than queued
  assign accept     = cmd_wr && op_known && st == fault_pkg::S_IDLE;
  assign val_ok     = val == fault_pkg::DTO_FOUR || val == fault_pkg::DTO_SEVEN;

  // Read data is caught in the setup cycle so it is steady for the access
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr_in)
        fault_pkg::ADDR_DTO:    prdata_out <= {28'h000_0000, downlink_count_option};
        fault_pkg::ADDR_STATUS: prdata_out <= {29'h0000_0000, bad_value, rejected, busy};
        default:                prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Only the two legal counts are stored; anything else leaves it as it was
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      downlink_count_option <= fault_pkg::DTO_RESET;
    end else if (accept && op == fault_pkg::OP_DTO_SET && val_ok) begin
      downlink_count_option <= val;
    end
  end

  // Seven-downlink mode: inputs 5 to 7 join the matrix, backup two drops out
  assign downlink_enable_out[3:0] = 4'hF;
  assign downlink_enable_out[6:4] = {3{downlink_count_option == fault_pkg::DTO_SEVEN}};
  assign backup2_enable_out = downlink_count_option == fault_pkg::DTO_FOUR;
  assign downlink_count_option_out = downlink_count_option;

  // Sticky error flags; write one to clear, a new event wins over the clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rejected  <= 1'b0;
      bad_value <= 1'b0;
    end else begin
      if (cmd_wr && !accept) begin
        rejected <= 1'b1;
      end else if (wr && paddr_in == fault_pkg::ADDR_STATUS && pwdata_in[fault_pkg::ST_REJECT]) begin
        rejected <= 1'b0;
      end
      if (accept && op == fault_pkg::OP_DTO_SET && !val_ok) begin
        bad_value <= 1'b1;
      end else if (wr && paddr_in == fault_pkg::ADDR_STATUS && pwdata_in[fault_pkg::ST_BADVAL]) begin
        bad_value <= 1'b0;
      end
    end
  end

  // Byte that the sequencer hands to the output register next
  always_comb begin
    case (st)
      fault_pkg::S_ECHO: cur_byte = is_bulk ? fault_pkg::BULK_ECHO[cnt[2:0]]
                                            : fault_pkg::DTO_ECHO[cnt[1:0]];
      fault_pkg::S_BODY: cur_byte = is_bulk ? pk.chr
                                            : fault_pkg::CH_DIGIT_BASE +
                                              {4'h0, downlink_count_option};
      fault_pkg::S_CR:   cur_byte = fault_pkg::CH_CR;
      fault_pkg::S_LF:   cur_byte = fault_pkg::CH_LF;
      default:           cur_byte = 8'h00;
    endcase
  end

  assign load = st != fault_pkg::S_IDLE && (!tx_valid_out || tx_ready_in);

  // Reply sequencer: echo, body, CR, LF
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st      <= fault_pkg::S_IDLE;
      cnt     <= 5'h00;
      is_bulk <= 1'b0;
    end else begin
      case (st)
        fault_pkg::S_IDLE: begin
          if (accept) begin
            st      <= fault_pkg::S_ECHO;
            cnt     <= 5'h00;
            is_bulk <= op == fault_pkg::OP_BULK;
          end
        end
        fault_pkg::S_ECHO: begin
          if (load) begin
            if (cnt == (is_bulk ? fault_pkg::BULK_ECHO_LAST : fault_pkg::DTO_ECHO_LAST)) begin
              st  <= fault_pkg::S_BODY;
              cnt <= 5'h00;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
        end
        fault_pkg::S_BODY: begin
          if (load) begin
            if (cnt == (is_bulk ? fault_pkg::BULK_BODY_LAST : 5'h00)) begin
              st <= fault_pkg::S_CR;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
        end
        fault_pkg::S_CR: begin
          if (load) begin
            st <= fault_pkg::S_LF;
          end
        end
        fault_pkg::S_LF: begin
          if (load) begin
            st <= fault_pkg::S_IDLE;
          end
        end
        default: begin
          st <= fault_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Output register: one byte in flight, refilled in the cycle it is taken
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
    end else if (load) begin
      tx_valid_out <= 1'b1;
      tx_data_out  <= cur_byte;
    end else if (tx_ready_in) begin
      tx_valid_out <= 1'b0;
    end
  end

  a_option_legal: assert property (@(posedge clk_in) disable iff (!rst_n)
    downlink_count_option == fault_pkg::DTO_FOUR || downlink_count_option == fault_pkg::DTO_SEVEN)
    else $error("downlink count option holds an illegal value");

  a_option_set: assert property (@(posedge clk_in) disable iff (!rst_n)
    accept && op == fault_pkg::OP_DTO_SET && val_ok |=> downlink_count_option == $past(val))
    else $error("legal downlink count not stored");

  a_option_keep: assert property (@(posedge clk_in) disable iff (!rst_n)
    accept && op == fault_pkg::OP_DTO_SET && !val_ok |=> $stable(downlink_count_option) && bad_value)
    else $error("illegal downlink count changed the option");

  a_seven_mode: assert property (@(posedge clk_in) disable iff (!rst_n)
    downlink_count_option == fault_pkg::DTO_SEVEN |-> downlink_enable_out == 7'h7F && !backup2_enable_out)
    else $error("seven downlink mode outputs wrong");

  a_four_mode: assert property (@(posedge clk_in) disable iff (!rst_n)
    downlink_count_option == fault_pkg::DTO_FOUR |-> downlink_enable_out == 7'h0F && backup2_enable_out)
    else $error("four downlink mode outputs wrong");

  a_digit_echo: assert property (@(posedge clk_in) disable iff (!rst_n)
    st == fault_pkg::S_CR && !is_bulk && tx_valid_out |->
      tx_data_out == fault_pkg::CH_DIGIT_BASE + {4'h0, downlink_count_option})
    else $error("downlink count echo wrong");

  a_body_print: assert property (@(posedge clk_in) disable iff (!rst_n)
    is_bulk && tx_valid_out && (st == fault_pkg::S_BODY && cnt != 5'h00 || st == fault_pkg::S_CR) |->
      tx_data_out[7:6] == fault_pkg::CH_PRINT_TOP)
    else $error("status character not printable");

  a_reply_tail: assert property (@(posedge clk_in) disable iff (!rst_n)
    tx_valid_out && tx_ready_in && tx_data_out == fault_pkg::CH_CR |=>
      tx_valid_out && tx_data_out == fault_pkg::CH_LF ##1 st == fault_pkg::S_IDLE)
    else $error("CR not followed by LF");

  a_echo_first: assert property (@(posedge clk_in) disable iff (!rst_n)
    accept && op == fault_pkg::OP_BULK |=> ##1 tx_valid_out && tx_data_out == fault_pkg::BULK_ECHO[0])
    else $error("bulk reply does not start with the echo");

  a_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n)
    cmd_wr && !accept |=> rejected)
    else $error("refused command not flagged");

  c_bulk_reply: cover property (@(posedge clk_in) disable iff (!rst_n)
    is_bulk && st == fault_pkg::S_LF && load);
  c_set_seven: cover property (@(posedge clk_in) disable iff (!rst_n)
    accept && op == fault_pkg::OP_DTO_SET && val == fault_pkg::DTO_SEVEN);
  c_stall: cover property (@(posedge clk_in) disable iff (!rst_n)
    tx_valid_out && !tx_ready_in ##1 tx_valid_out && !tx_ready_in);
  c_refused: cover property (@(posedge clk_in) disable iff (!rst_n)
    cmd_wr && busy);
endmodule

// ### test/host_link_sink.sv
`timescale 1ns/1ns
module host_link_sink (
  input  wire logic       clk_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  logic [7:0] got[$];
  logic       pend = 1'b0;
  logic [7:0] last = 8'h00;
  int         hold_err = 0;

  initial tx_ready_out = 1'b0;

  // A stalled byte must stand unchanged until it is taken
  always @(posedge clk_in) begin
    if (pend && (tx_valid_in !== 1'b1 || tx_data_in !== last)) begin
      hold_err++;
    end
    if (tx_valid_in === 1'b1 && tx_ready_out) begin
      got.push_back(tx_data_in);
    end
    pend <= tx_valid_in && !tx_ready_out;
    last <= tx_data_in;
    tx_ready_out <= slow_in ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule

// ### test/bulk_fault_status_packer_tb_top.sv
`timescale 1ns/1ns
module bulk_fault_status_packer_tb_top;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         psel_in = 1'b0;
  logic         penable_in = 1'b0;
  logic         pwrite_in = 1'b0;
  logic         slow = 1'b0;
  logic         pready_out, pslverr_out, tx_valid_out, tx_ready_in, backup2_enable_out, er;
  logic [7:0]   paddr_in = 8'h00;
  logic [31:0]  pwdata_in = 32'h0;
  logic [31:0]  prdata_out, rd;
  logic [7:0]   tx_data_out;
  logic [6:0]   downlink_enable_out;
  logic [3:0]   downlink_count_option_out;
  logic [9:0]   mod_fault_in, dmd_fault_in, mod_cfg_fault_in, dmd_cfg_fault_in;
  logic [9:0]   mod_compat_fault_in, dmd_compat_fault_in, no_mod_cfg_in, no_dmd_cfg_in;
  logic [9:0]   no_address_in, no_interface_in, comm_fault_in;
  logic [7:0]   mod_op_fault_in, dmd_op_fault_in, no_downlink_in;
  logic [6:0]   downlink_fault_in, common_fault_in;
  logic [147:0] flt = '0;
  logic [7:0]   exp_q[$];
  int           n_mismatch = 0;
  int           cmp_count = 0;
  int           opt = 4;

  assign {mod_fault_in, dmd_fault_in, mod_cfg_fault_in, dmd_cfg_fault_in, mod_compat_fault_in,
          dmd_compat_fault_in, no_mod_cfg_in, no_dmd_cfg_in, no_address_in, no_interface_in,
          comm_fault_in, mod_op_fault_in, dmd_op_fault_in, no_downlink_in,
          downlink_fault_in, common_fault_in} = flt;

  always #20 clk_in = ~clk_in;

  bulk_fault_status_packer dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .mod_fault_in,
    .dmd_fault_in, .mod_op_fault_in, .dmd_op_fault_in, .downlink_fault_in, .mod_cfg_fault_in,
    .dmd_cfg_fault_in, .mod_compat_fault_in, .dmd_compat_fault_in, .common_fault_in,
    .no_mod_cfg_in, .no_dmd_cfg_in, .no_address_in, .no_interface_in, .no_downlink_in,
    .comm_fault_in, .tx_data_out, .tx_valid_out, .tx_ready_in, .downlink_enable_out,
    .backup2_enable_out, .downlink_count_option_out);

  host_link_sink sink (.clk_in(clk_in), .slow_in(slow), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in));

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Starts one edge late so back-to-back calls never drive psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [3:0] v);
    apb(1'b1, fault_pkg::ADDR_CMD, {20'h0, v, op});
  endtask

  task automatic rnd(input bit ones);
    flt <= ones ? '1 : 148'({$urandom, $urandom, $urandom, $urandom, $urandom});
  endtask

  function automatic logic [7:0] ch(input logic [5:0] f);
    return {2'h1, f[0], f[1], f[2], f[3], f[4], f[5]};
  endfunction

  task automatic pair(input logic [9:0] v);
    exp_q.push_back(ch(v[5:0]));
    exp_q.push_back(ch({2'h0, v[9:6]}));
  endtask

  task automatic tail();
    exp_q.push_back(fault_pkg::CH_CR);
    exp_q.push_back(fault_pkg::CH_LF);
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((sink.got.size() < exp_q.size() || tx_valid_out !== 1'b0) && k < 3000) begin
      @(posedge clk_in);
      k++;
    end
    chk(32'(sink.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) chk(32'(sink.got[i]), 32'(exp_q[i]));
    exp_q.delete();
    sink.got.delete();
  endtask

  task automatic bulk();
    for (int i = 0; i < 5; i++) exp_q.push_back(fault_pkg::BULK_ECHO[i]);
    pair(mod_fault_in);
    pair(dmd_fault_in);
    exp_q.push_back(ch(mod_op_fault_in[5:0]));
    exp_q.push_back(ch({4'h0, mod_op_fault_in[7:6]}));
    exp_q.push_back(ch(dmd_op_fault_in[5:0]));
    exp_q.push_back(ch({downlink_fault_in[3:0], dmd_op_fault_in[7:6]}));
    exp_q.push_back(ch({3'h0, downlink_fault_in[6:4]}));
    pair(mod_cfg_fault_in);
    pair(dmd_cfg_fault_in);
    pair(mod_compat_fault_in);
    pair(dmd_compat_fault_in);
    exp_q.push_back(ch(common_fault_in[5:0]));
    exp_q.push_back(ch({5'h0, common_fault_in[6]}));
    pair(no_mod_cfg_in);
    pair(no_dmd_cfg_in);
    pair(no_address_in);
    pair(no_interface_in);
    exp_q.push_back(ch(no_downlink_in[5:0]));
    exp_q.push_back(ch({4'h0, no_downlink_in[7:6]}));
    pair(comm_fault_in);
    tail();
    cmd(fault_pkg::OP_BULK, 4'h0);
    // Inputs move right after the accepting edge; the reply must keep the snapshot
    rnd(1'b0);
  endtask

  task automatic count(input logic [7:0] op, input logic [3:0] v);
    for (int i = 0; i < 4; i++) exp_q.push_back(fault_pkg::DTO_ECHO[i]);
    if (op == fault_pkg::OP_DTO_SET && (v == 4'h4 || v == 4'h7)) opt = v;
    exp_q.push_back(8'(fault_pkg::CH_DIGIT_BASE + 8'(opt)));
    tail();
    cmd(op, v);
    drain();
    apb(1'b0, fault_pkg::ADDR_DTO, 32'h0);
    chk(32'(rd[3:0]), 32'(opt));
    chk(32'(downlink_count_option_out), 32'(opt));
    chk(32'(downlink_enable_out), (opt == 7) ? 32'h7F : 32'h0F);
    chk(32'(backup2_enable_out), 32'(opt == 4));
  endtask

  task automatic status(input int bitpos, input logic val);
    apb(1'b0, fault_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[bitpos]), 32'(val));
    if (bitpos != fault_pkg::ST_BUSY) apb(1'b1, fault_pkg::ADDR_STATUS, 32'(1) << bitpos);
  endtask

  initial begin
    #800000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(58));
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    // Option register is read-only; this write must leave it at four
    apb(1'b1, fault_pkg::ADDR_DTO, 32'h7);
    count(fault_pkg::OP_DTO_QUERY, 4'h0);
    count(fault_pkg::OP_DTO_SET, 4'h7);
    count(fault_pkg::OP_DTO_QUERY, 4'h0);
    count(fault_pkg::OP_DTO_SET, 4'h5);
    status(fault_pkg::ST_BADVAL, 1'b1);
    status(fault_pkg::ST_BADVAL, 1'b0);
    count(fault_pkg::OP_DTO_SET, 4'h4);
    cmd(8'h09, 4'h0);
    status(fault_pkg::ST_REJECT, 1'b1);
    drain();
    for (int i = 0; i < 8; i++) begin
      rnd(i == 7);
      slow <= i[0];
      @(posedge clk_in);
      bulk();
      if (i == 0) begin
        status(fault_pkg::ST_BUSY, 1'b1);
        cmd(fault_pkg::OP_DTO_QUERY, 4'h0);
        status(fault_pkg::ST_REJECT, 1'b1);
      end
      drain();
    end
    chk(32'(sink.hold_err), 32'h0);
    wrap_up();
  end
endmodule
